// *** hdl/sfr_space_consts.svh ***
// Constants of the special-purpose register space decoder.
// Assumes inclusion by bare name from the package and the decoder.
`ifndef SFR_SPACE_CONSTS_SVH
`define SFR_SPACE_CONSTS_SVH

// ----------------------------------------
// Offsets inside the special-purpose area
// ----------------------------------------
`define OFS_INDIRECT_PORT_A 8'h00
`define OFS_POINTER_A 8'h01
`define OFS_INDIRECT_PORT_B 8'h02
`define OFS_POINTER_B_LOW 8'h03
`define OFS_POINTER_B_HIGH 8'h04
`define OFS_INDIRECT_PORT_C 8'h0C
`define OFS_POINTER_C_LOW 8'h0D
`define OFS_POINTER_C_HIGH 8'h0E

// ----------------------------------------
// Address layout and values
// ----------------------------------------
`define GP_AREA_BIT 7
`define SECTOR_WIDTH 4
`define SECTOR_LSB 8
`define SECTOR_ZERO 4'h0
`define SFR_SECTOR_COUNT 5'h02
`define ZERO_BYTE 8'h00
`define POINTER_RESET 8'h00

`endif

// *** hdl/sfr_space_pkg.sv ***
// Types shared by the special-purpose register space decoder.
// Assumes the constants header is on the include path.
`include "sfr_space_consts.svh"

package sfr_space_pkg;
    // Where a resolved access lands
    typedef enum logic [1:0] {
        tgt_none,
        tgt_pointer,
        tgt_periph,
        tgt_ram
    } target_type;
endpackage : sfr_space_pkg

// *** hdl/sfr_space_decoder.sv ***
// Special-purpose register space decoder with three indirect-access ports
// and the general-purpose RAM of all sectors.
// Assumes a CPU core that issues one access at a time on the cpu_ port and
// peripheral blocks that answer on the periph_ port within the same cycle.
//
// Functional notes
// - A read of a special-purpose location with no register returns 00H.
// - Writes to reserved locations leave them unchanged.
// - Protected registers are read-only; CPU writes to them have no effect.
// - An access to an indirect port is carried out at the location its pointer names.
// - Indirect port a with its single pointer reaches sector 0 only.
// - Indirect ports b and c with their pointer pairs reach every sector.
// - An indirect port read as storage returns 00H and writes to it are dropped.
// - The high pointer selects the sector and the low pointer the address in it.
// - Addresses 00H-7FH are special-purpose registers, 80H-FFH general-purpose RAM.
`timescale 1ns/100ps
`include "sfr_space_consts.svh"

module sfr_space_decoder
    import sfr_space_pkg::*;
#(
    parameter int SECTORS = 16
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic cpu_req,
    input wire logic cpu_we,
    input wire logic [11:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    output logic cpu_ready,
    output logic [7:0] cpu_rdata,
    output logic cpu_ack,
    output logic periph_sel,
    output logic periph_we,
    output logic [11:0] periph_addr,
    output logic [7:0] periph_wdata,
    input wire logic [7:0] periph_rdata,
    input wire logic periph_hit,
    input wire logic periph_ro
);

    // Sector field is four bits; the special-purpose area needs two sectors
    if (SECTORS < 2 || SECTORS > 16) begin : g_sectors_check
        $error("SECTORS must lie between 2 and 16");
    end

    localparam int RAM_WORDS = SECTORS * 128;

    // ----------------------------------------
    // Request resolution
    // ----------------------------------------
    logic [7:0] ptr_a_r, ptr_bl_r, ptr_bh_r, ptr_cl_r, ptr_ch_r;
    logic [7:0] ptr_a_nxt, ptr_bl_nxt, ptr_bh_nxt, ptr_cl_nxt, ptr_ch_nxt;
    logic take;
    logic [11:0] eff_addr;
    target_type eff_kind;
    logic [3:0] eff_sector;
    logic [7:0] eff_low;
    logic eff_is_port;
    logic s1_valid_r, s1_valid_nxt;
    logic s1_we_r, s1_we_nxt;
    logic [11:0] s1_addr_r, s1_addr_nxt;
    logic [7:0] s1_wdata_r, s1_wdata_nxt;
    target_type s1_kind_r, s1_kind_nxt;

    assign cpu_ready = !s1_valid_r;
    assign take = cpu_req && cpu_ready;

    function automatic logic is_port(input logic [7:0] ofs);
        is_port = ofs == `OFS_INDIRECT_PORT_A || ofs == `OFS_INDIRECT_PORT_B || ofs == `OFS_INDIRECT_PORT_C;
    endfunction : is_port

    function automatic logic is_pointer(input logic [7:0] ofs);
        is_pointer = ofs == `OFS_POINTER_A || ofs == `OFS_POINTER_B_LOW || ofs == `OFS_POINTER_B_HIGH
            || ofs == `OFS_POINTER_C_LOW || ofs == `OFS_POINTER_C_HIGH;
    endfunction : is_pointer

    // Ports exist in sector 0 only; the same offsets in sector 1 go to peripherals
    always_comb begin
        eff_addr = cpu_addr;
        if (cpu_addr[11:8] == `SECTOR_ZERO) begin
            case (cpu_addr[7:0])
                `OFS_INDIRECT_PORT_A: eff_addr = {`SECTOR_ZERO, ptr_a_r};
                `OFS_INDIRECT_PORT_B: eff_addr = {ptr_bh_r[3:0], ptr_bl_r};
                `OFS_INDIRECT_PORT_C: eff_addr = {ptr_ch_r[3:0], ptr_cl_r};
                default: eff_addr = cpu_addr;
            endcase
        end
        eff_sector = eff_addr[11:8];
        eff_low = eff_addr[7:0];
        eff_is_port = eff_sector == `SECTOR_ZERO && is_port(eff_low);
        if (eff_low[`GP_AREA_BIT]) begin
            eff_kind = ({1'b0, eff_sector} < 5'(SECTORS)) ? tgt_ram : tgt_none;
        end else if (eff_is_port) begin
            eff_kind = tgt_none;
        end else if (eff_sector == `SECTOR_ZERO && is_pointer(eff_low)) begin
            eff_kind = tgt_pointer;
        end else if ({1'b0, eff_sector} < `SFR_SECTOR_COUNT) begin
            eff_kind = tgt_periph;
        end else begin
            eff_kind = tgt_none;
        end
    end

    // ----------------------------------------
    // Stage 1: resolved access
    // ----------------------------------------
    // One access in flight; the CPU is held off for the cycle after a take

    always_comb begin
        s1_valid_nxt = take;
        s1_we_nxt = s1_we_r;
        s1_addr_nxt = s1_addr_r;
        s1_wdata_nxt = s1_wdata_r;
        s1_kind_nxt = s1_kind_r;
        if (take) begin
            s1_we_nxt = cpu_we;
            s1_addr_nxt = eff_addr;
            s1_wdata_nxt = cpu_wdata;
            s1_kind_nxt = eff_kind;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1_valid_r <= 1'b0;
            s1_we_r <= 1'b0;
            s1_addr_r <= 12'h000;
            s1_wdata_r <= `ZERO_BYTE;
            s1_kind_r <= tgt_none;
        end else begin
            s1_valid_r <= s1_valid_nxt;
            s1_we_r <= s1_we_nxt;
            s1_addr_r <= s1_addr_nxt;
            s1_wdata_r <= s1_wdata_nxt;
            s1_kind_r <= s1_kind_nxt;
        end
    end

    // ----------------------------------------
    // Peripheral side
    // ----------------------------------------
    assign periph_sel = s1_valid_r && s1_kind_r == tgt_periph;
    assign periph_we = periph_sel && s1_we_r && periph_hit && !periph_ro;
    assign periph_addr = s1_addr_r;
    assign periph_wdata = s1_wdata_r;

    // ----------------------------------------
    // Memory pointers
    // ----------------------------------------
    logic ptr_wr;

    always_comb begin
        ptr_wr = s1_valid_r && s1_we_r && s1_kind_r == tgt_pointer;
        ptr_a_nxt = ptr_a_r;
        ptr_bl_nxt = ptr_bl_r;
        ptr_bh_nxt = ptr_bh_r;
        ptr_cl_nxt = ptr_cl_r;
        ptr_ch_nxt = ptr_ch_r;
        if (ptr_wr) begin
            case (s1_addr_r[7:0])
                `OFS_POINTER_A: ptr_a_nxt = s1_wdata_r;
                `OFS_POINTER_B_LOW: ptr_bl_nxt = s1_wdata_r;
                `OFS_POINTER_B_HIGH: ptr_bh_nxt = s1_wdata_r;
                `OFS_POINTER_C_LOW: ptr_cl_nxt = s1_wdata_r;
                `OFS_POINTER_C_HIGH: ptr_ch_nxt = s1_wdata_r;
                default: ptr_a_nxt = ptr_a_r;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_a_r <= `POINTER_RESET;
            ptr_bl_r <= `POINTER_RESET;
            ptr_bh_r <= `POINTER_RESET;
            ptr_cl_r <= `POINTER_RESET;
            ptr_ch_r <= `POINTER_RESET;
        end else begin
            ptr_a_r <= ptr_a_nxt;
            ptr_bl_r <= ptr_bl_nxt;
            ptr_bh_r <= ptr_bh_nxt;
            ptr_cl_r <= ptr_cl_nxt;
            ptr_ch_r <= ptr_ch_nxt;
        end
    end

    // ----------------------------------------
    // General-purpose RAM
    // ----------------------------------------
    // Not reset; contents are undefined until written
    logic [7:0] ram [RAM_WORDS];
    logic [10:0] ram_idx;

    assign ram_idx = {s1_addr_r[11:8], s1_addr_r[6:0]};

    always_ff @(posedge mclk) begin
        if (s1_valid_r && s1_we_r && s1_kind_r == tgt_ram) begin
            ram[ram_idx] <= s1_wdata_r;
        end
    end

    // ----------------------------------------
    // Read data and answer
    // ----------------------------------------
    logic [7:0] cpu_rdata_nxt;
    logic [7:0] ptr_rd;

    always_comb begin
        case (s1_addr_r[7:0])
            `OFS_POINTER_A: ptr_rd = ptr_a_r;
            `OFS_POINTER_B_LOW: ptr_rd = ptr_bl_r;
            `OFS_POINTER_B_HIGH: ptr_rd = ptr_bh_r;
            `OFS_POINTER_C_LOW: ptr_rd = ptr_cl_r;
            `OFS_POINTER_C_HIGH: ptr_rd = ptr_ch_r;
            default: ptr_rd = `ZERO_BYTE;
        endcase
        cpu_rdata_nxt = cpu_rdata;
        if (s1_valid_r && !s1_we_r) begin
            case (s1_kind_r)
                tgt_ram: cpu_rdata_nxt = ram[ram_idx];
                tgt_pointer: cpu_rdata_nxt = ptr_rd;
                tgt_periph: cpu_rdata_nxt = periph_hit ? periph_rdata : `ZERO_BYTE;
                default: cpu_rdata_nxt = `ZERO_BYTE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_rdata <= `ZERO_BYTE;
            cpu_ack <= 1'b0;
        end else begin
            cpu_rdata <= cpu_rdata_nxt;
            cpu_ack <= s1_valid_r;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    unused_read_zero_a: assert property (s1_valid_r && !s1_we_r && s1_kind_r == tgt_none
        |=> cpu_ack && cpu_rdata == `ZERO_BYTE) else $error("unused read not zero");
    unmapped_read_zero_a: assert property (periph_sel && !s1_we_r && !periph_hit
        |=> cpu_rdata == `ZERO_BYTE) else $error("unmapped register not read as zero");
    high_sector_none_a: assert property (take && {1'b0, cpu_addr[11:8]} >= `SFR_SECTOR_COUNT
        && !cpu_addr[`GP_AREA_BIT] |=> s1_kind_r == tgt_none) else $error("sfr area of high sector mapped");
    reserved_write_held_a: assert property (periph_sel && periph_ro
        |-> !periph_we) else $error("write reached protected location");
    unmapped_write_held_a: assert property (periph_sel && !periph_hit
        |-> !periph_we) else $error("write reached unmapped location");
    periph_write_gate_a: assert property (periph_we
        |-> periph_sel && s1_we_r) else $error("stray peripheral write");
    port_a_target_a: assert property (take && cpu_addr == {`SECTOR_ZERO, `OFS_INDIRECT_PORT_A}
        |=> s1_addr_r[7:0] == $past(ptr_a_r)) else $error("port a misdirected");
    port_b_target_a: assert property (take && cpu_addr == {`SECTOR_ZERO, `OFS_INDIRECT_PORT_B}
        |=> s1_addr_r == {4'($past(ptr_bh_r)), $past(ptr_bl_r)}) else $error("port b misdirected");
    port_a_sector_a: assert property (take && cpu_addr == {`SECTOR_ZERO, `OFS_INDIRECT_PORT_A}
        |=> s1_addr_r[11:8] == `SECTOR_ZERO) else $error("port a left sector 0");
    port_c_sector_a: assert property (take && cpu_addr == {`SECTOR_ZERO, `OFS_INDIRECT_PORT_C}
        |=> s1_addr_r[11:8] == 4'($past(ptr_ch_r))) else $error("port c sector wrong");
    port_c_low_a: assert property (take && cpu_addr == {`SECTOR_ZERO, `OFS_INDIRECT_PORT_C}
        |=> s1_addr_r[7:0] == $past(ptr_cl_r)) else $error("port c address wrong");
    port_self_none_a: assert property (take && eff_is_port
        |=> s1_kind_r == tgt_none ##1 cpu_ack) else $error("port read as storage");
    ram_area_a: assert property (s1_valid_r && s1_kind_r == tgt_ram
        |-> s1_addr_r[`GP_AREA_BIT]) else $error("ram outside upper half");
    periph_low_half_a: assert property (periph_sel
        |-> !periph_addr[`GP_AREA_BIT]) else $error("peripheral access in upper half");
    pointer_write_a: assert property (ptr_wr && s1_addr_r[7:0] == `OFS_POINTER_A
        |=> ptr_a_r == $past(s1_wdata_r)) else $error("pointer a not updated");
    ptr_bl_write_a: assert property (ptr_wr && s1_addr_r[7:0] == `OFS_POINTER_B_LOW
        |=> ptr_bl_r == $past(s1_wdata_r)) else $error("pointer b low not updated");
    ptr_bh_write_a: assert property (ptr_wr && s1_addr_r[7:0] == `OFS_POINTER_B_HIGH
        |=> ptr_bh_r == $past(s1_wdata_r)) else $error("pointer b high not updated");
    ptr_cl_write_a: assert property (ptr_wr && s1_addr_r[7:0] == `OFS_POINTER_C_LOW
        |=> ptr_cl_r == $past(s1_wdata_r)) else $error("pointer c low not updated");
    ptr_ch_write_a: assert property (ptr_wr && s1_addr_r[7:0] == `OFS_POINTER_C_HIGH
        |=> ptr_ch_r == $past(s1_wdata_r)) else $error("pointer c high not updated");
    pointer_hold_a: assert property (!ptr_wr
        |=> $stable(ptr_a_r) && $stable(ptr_bl_r) && $stable(ptr_bh_r) && $stable(ptr_cl_r) && $stable(ptr_ch_r))
        else $error("pointer changed without write");
    ack_timing_a: assert property (take |=> !cpu_ack ##1 cpu_ack) else $error("answer not two cycles");
    ready_gap_a: assert property (take |=> !cpu_ready ##1 cpu_ready) else $error("ready not low for one cycle");
    ack_source_a: assert property (cpu_ack |-> $past(s1_valid_r)) else $error("answer without access");
    rdata_hold_a: assert property (!(s1_valid_r && !s1_we_r) |=> $stable(cpu_rdata)) else $error("read data moved");

    // ----------------------------------------
    // Cover points
    // ----------------------------------------
    ram_indirect_c: cover property (take && cpu_addr == {`SECTOR_ZERO, `OFS_INDIRECT_PORT_B} && cpu_we
        ##1 s1_kind_r == tgt_ram);
    unused_read_c: cover property (s1_valid_r && !s1_we_r && s1_kind_r == tgt_none);
    protected_write_c: cover property (periph_sel && s1_we_r && periph_ro);
    port_c_far_c: cover property (take && cpu_addr == {`SECTOR_ZERO, `OFS_INDIRECT_PORT_C}
        ##1 s1_kind_r == tgt_ram && s1_addr_r[11:8] != `SECTOR_ZERO);
    back_to_back_c: cover property (take ##2 take);

endmodule : sfr_space_decoder

// *** tb/periph_model.sv ***
// Peripheral register model on the decoder's peripheral side.
// Assumes the decoder raises periph_we only for assigned, writable places.
`timescale 1ns/100ps

module periph_model (
    input wire logic mclk,
    input wire logic periph_sel,
    input wire logic periph_we,
    input wire logic [11:0] periph_addr,
    input wire logic [7:0] periph_wdata,
    output logic [7:0] periph_rdata,
    output logic periph_hit,
    output logic periph_ro
);
    logic [7:0] regs [0:255];
    logic [7:0] idx;
    assign idx = {periph_addr[8], periph_addr[6:0]};
    // Assigned places: offsets 05-0A and 10-1F of sectors 0 and 1
    assign periph_hit = (periph_addr[11:9] == 3'h0) && (periph_addr[6:0] inside {[7'h05:7'h0A], [7'h10:7'h1F]});
    assign periph_ro = periph_hit && (periph_addr[6:0] inside {[7'h10:7'h13]});
    // Unassigned places show garbage that the decoder must hide
    assign periph_rdata = periph_hit ? regs[idx] : ~regs[idx];
    initial begin
        for (int i = 0; i < 256; i++) begin
            regs[i] = i[7:0] ^ 8'hA5;
        end
    end
    always @(posedge mclk) begin
        if (periph_sel && periph_we) begin
            regs[idx] <= periph_wdata;
        end
    end
endmodule : periph_model

// *** tb/tb.sv ***
// Self-checking bench of the special-purpose register space decoder.
// Assumes the constants header on the include path and periph_model.
`timescale 1ns/100ps
`include "sfr_space_consts.svh"

module tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic cpu_req = 1'b0;
    logic cpu_we = 1'b0;
    logic [11:0] cpu_addr = 12'h000;
    logic [7:0] cpu_wdata = 8'h00;
    logic cpu_ready, cpu_ack, periph_sel, periph_we, periph_hit, periph_ro;
    logic [7:0] cpu_rdata, periph_wdata, periph_rdata;
    logic [11:0] periph_addr;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;

    sfr_space_decoder #(.SECTORS(16)) u_sfr_space_decoder (.mclk(mclk), .rst_n(rst_n), .cpu_req(cpu_req),
        .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_ready(cpu_ready),
        .cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack), .periph_sel(periph_sel), .periph_we(periph_we),
        .periph_addr(periph_addr), .periph_wdata(periph_wdata), .periph_rdata(periph_rdata),
        .periph_hit(periph_hit), .periph_ro(periph_ro));
    periph_model u_periph_model (.mclk(mclk), .periph_sel(periph_sel), .periph_we(periph_we),
        .periph_addr(periph_addr), .periph_wdata(periph_wdata), .periph_rdata(periph_rdata),
        .periph_hit(periph_hit), .periph_ro(periph_ro));

    initial begin
        forever #5 mclk = ~mclk;
    end

    task automatic wrap_up;
        if (num_errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 1000) begin
            num_errors++;
            wrap_up();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    // One access: taken at the next edge, answered at the edge after that
    task automatic acc(input logic we, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
        check({7'h00, cpu_ready}, 8'h01, "ready before request");
        cpu_req = 1'b1;
        cpu_we = we;
        cpu_addr = a;
        cpu_wdata = d;
        @(posedge mclk);
        #1;
        check({7'h00, cpu_ready}, 8'h00, "busy after take");
        cpu_req = 1'b0;
        @(posedge mclk);
        #1;
        check({7'h00, cpu_ack}, 8'h01, "ack");
        q = cpu_rdata;
    endtask : acc

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] q;
        acc(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp, input string msg);
        logic [7:0] q;
        acc(1'b0, a, 8'h00, q);
        check(q, exp, msg);
    endtask : rd_chk

    task automatic t_pointers;
        logic [7:0] ofs [5];
        ofs = '{`OFS_POINTER_A, `OFS_POINTER_B_LOW, `OFS_POINTER_B_HIGH, `OFS_POINTER_C_LOW, `OFS_POINTER_C_HIGH};
        for (int i = 0; i < 5; i++) begin
            rd_chk({4'h0, ofs[i]}, `POINTER_RESET, "pointer reset");
            wr({4'h0, ofs[i]}, 8'h5A ^ i[7:0]);
            rd_chk({4'h0, ofs[i]}, 8'h5A ^ i[7:0], "pointer readback");
        end
    endtask : t_pointers

    task automatic t_port_a;
        wr(12'h190, 8'h77);
        wr({4'h0, `OFS_POINTER_A}, 8'h90);
        wr({4'h0, `OFS_INDIRECT_PORT_A}, 8'h3C);
        rd_chk(12'h090, 8'h3C, "port a write");
        rd_chk(12'h190, 8'h77, "sector 1 untouched");
        rd_chk({4'h0, `OFS_INDIRECT_PORT_A}, 8'h3C, "port a read");
    endtask : t_port_a

    task automatic t_ports_bc;
        logic [7:0] port [2];
        logic [7:0] lo [2];
        logic [3:0] sec;
        port = '{`OFS_INDIRECT_PORT_B, `OFS_INDIRECT_PORT_C};
        lo = '{`OFS_POINTER_B_LOW, `OFS_POINTER_C_LOW};
        for (int j = 0; j < 2; j++) begin
            sec = j[0] ? 4'hF : 4'h3;
            wr({4'h0, lo[j] + 8'h01}, {4'hA, sec});
            wr({4'h0, lo[j]}, 8'hC4);
            wr({4'h0, port[j]}, 8'h61 + j[7:0]);
            rd_chk({sec, 8'hC4}, 8'h61 + j[7:0], "indirect write");
            wr({sec, 8'hC4}, 8'h1E);
            rd_chk({4'h0, port[j]}, 8'h1E, "indirect read");
            wr({4'h0, lo[j] + 8'h01}, 8'h01);
            wr({4'h0, lo[j]}, 8'h06);
            rd_chk({4'h0, port[j]}, 8'h23, "indirect to sector 1 register");
        end
    endtask : t_ports_bc

    task automatic t_map;
        rd_chk(12'h00B, 8'h00, "unassigned");
        rd_chk(12'h27F, 8'h00, "sector 2 area");
        wr(12'h010, 8'h11);
        rd_chk(12'h010, 8'hB5, "protected");
        wr(12'h113, 8'h22);
        rd_chk(12'h113, 8'h36, "reserved");
        wr(12'h105, 8'h42);
        wr(12'h185, 8'h24);
        rd_chk(12'h105, 8'h42, "register area");
        rd_chk(12'h185, 8'h24, "ram area");
    endtask : t_map

    task automatic t_storage;
        wr({4'h0, `OFS_POINTER_A}, `OFS_INDIRECT_PORT_B);
        wr({4'h0, `OFS_INDIRECT_PORT_A}, 8'h99);
        rd_chk({4'h0, `OFS_INDIRECT_PORT_A}, `ZERO_BYTE, "port as storage");
        wr({4'h0, `OFS_POINTER_A}, `OFS_INDIRECT_PORT_A);
        rd_chk({4'h0, `OFS_INDIRECT_PORT_A}, `ZERO_BYTE, "port on itself");
    endtask : t_storage

    task automatic t_reset;
        wr({4'h0, `OFS_POINTER_B_LOW}, 8'h3B);
        rst_n = 1'b0;
        @(posedge mclk);
        #1;
        rst_n = 1'b1;
        rd_chk({4'h0, `OFS_POINTER_B_LOW}, `POINTER_RESET, "pointer after reset");
        rd_chk(12'h185, 8'h24, "ram kept over reset");
    endtask : t_reset

    initial begin
        repeat (4) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        t_pointers();
        t_port_a();
        t_ports_bc();
        t_map();
        t_storage();
        t_reset();
        wrap_up();
    end
endmodule : tb
